//--- logic/pmm_pkg.sv
/*
 Shared constants and types for the logic and memory power manager:
 control register layout, reset value, counter limits, pin modes, power states.
 Assumes nothing of its surroundings.
*/
package pmm_pkg;

	localparam int          REG_W           = 8;
	localparam logic [7:0]  PMC0_RESET      = 8'h00;
	localparam logic [7:0]  PMC0_USED_MASK  = 8'h3A;
	localparam int          APD_EN_BIT      = 1;
	localparam int          FAST_OFF_BIT    = 3;
	localparam int          BLOCK_COMMON_CLOCK_IN_BIT = 4;
	localparam int          BLOCK_OMC_BIT   = 5;
	localparam int          APD_CNT_W       = 4;
	localparam logic [3:0]  APD_MAX         = 4'hF;
	localparam int          NUM_OMC         = 16;
	localparam int          ADDR_W          = 16;
	localparam int          NUM_AUX         = 2;
	localparam int          SYNC_STAGES     = 2;
	localparam int          CLK_PERIOD_NS   = 4;

	// pin 0 dedicated = common clock in, pin 1 dedicated = chip-select input
	typedef enum logic [1:0] {
		AUX_MCU_IO    = 2'h0,
		AUX_CS_OUT    = 2'h1,
		AUX_DEDICATED = 2'h2,
		AUX_LOGIC_IN  = 2'h3
	} aux_mode_t;

	typedef enum logic [1:0] {
		PS_RUN   = 2'h0,
		PS_COUNT = 2'h1,
		PS_DOWN  = 2'h3
	} pd_state_t;

endpackage

//--- logic/pmm_sync.sv
/*
 Two-stage synchroniser bank for inputs arriving from pins.
 Assumes sys_clk domain, synchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ns
module pmm_sync #(
	parameter int WIDTH = 3
) (
	input  wire logic             sys_clk, // system clock
	input  wire logic             nrst,    // synchronous reset, active low
	input  wire logic             ce,      // clock enable
	input  wire logic [WIDTH-1:0] d_async, // pin levels
	output logic      [WIDTH-1:0] q_sync   // synchronised levels
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_q;

	always_comb begin
		next_meta = meta;
		next_q    = q_sync;
		if (!nrst) begin
			next_meta = '0;
			next_q    = '0;
		end else if (ce) begin
			next_meta = d_async;
			next_q    = meta;
		end
	end

	always_ff @(posedge sys_clk) begin
		meta   <= next_meta;
		q_sync <= next_q;
	end
endmodule

//--- logic/pld_memory_power_manager.sv
/*
 Power manager of the programmable logic and memory module: two auxiliary
 pins with selectable modes, zero-power memory wake, automatic and forced
 power-down, chip-select standby, fast/low-power logic and strobe blocking.
 Assumes the MCU strobes, address and selects come from logic on sys_clk;
 the aux pins and the module reset pin are asynchronous and are synchronised.
 nrst is the power-up reset; module_rst_n is the later module reset pin.
*/
`timescale 1ns/1ns
// Functional notes
// R1: aux pins: MCU io, chip-select out, logic in
// R2: pin 0 clocks all output macrocells and counter
// R3: chip-select input high puts memories in standby
// R4: memories wake only on address change
// R5: no zero-power logic until software enables it
// R6: timeout shuts address and data buffers
// R7: strobes still reach logic during power-down
// R8: forced bit gives same power-down, no clock
// R9: chip-select input leaves buffers and logic running
// R10: fast logic default, low-power selectable
// R11: blocking bits gate bus strobes off logic
// R12: bit 1 enables the power-down counter
// R13: bit 3 selects low-power logic mode
// R14: bit 4 blocks clock-in from logic bus
// R15: bit 5 blocks clock-in from macrocells only
// R16: software writes zero to unused bits
// R17: 15 steady clock-in periods enter power-down
// R18: strobe transition before max clears counter
// R19: exit on strobe, chip-select fall, reset rise
// R20: control register cleared only at power-up
// R21: indicator is timeout OR forced bit
module pld_memory_power_manager #(
	parameter int ADDR_W  = pmm_pkg::ADDR_W,
	parameter int NUM_OMC = pmm_pkg::NUM_OMC
) (
	input  wire logic                             sys_clk,          // 250 MHz clock
	input  wire logic                             nrst,             // power-up reset, low
	input  wire logic                             ce,               // clock enable
	input  wire logic                             reg_wr,           // control write strobe
	input  wire logic [pmm_pkg::REG_W-1:0]        reg_wdata,        // control write data
	output logic      [pmm_pkg::REG_W-1:0]        reg_rdata,        // control read data
	input  wire logic                             forced_power_down,// forced power-down bit
	input  wire logic                             block_rd,         // block read strobe
	input  wire logic                             block_wr,         // block write strobe
	input  wire logic                             block_psen,       // block fetch strobe
	input  wire logic                             block_ale,        // block latch strobe
	input  wire pmm_pkg::aux_mode_t [1:0]         aux_mode,         // per-pin mode
	input  wire logic [1:0]                       aux_pin_in,       // pin levels
	output logic      [1:0]                       aux_pin_out,      // pin drive values
	output logic      [1:0]                       aux_pin_oe_n,     // pin drive, low = on
	input  wire logic [1:0]                       mcu_pin_out,      // MCU pin data
	input  wire logic [1:0]                       mcu_pin_dir,      // MCU pin is output
	output logic      [1:0]                       mcu_pin_in,       // pin data to MCU
	input  wire logic                             external_chip_select_1, // decode output 1
	input  wire logic                             external_chip_select_2, // decode output 2
	output logic      [1:0]                       logic_in_aux,     // direct logic inputs
	input  wire logic                             module_rst_n,     // module reset pin
	input  wire logic                             mcu_rd_n,         // read strobe
	input  wire logic                             mcu_wr_n,         // write strobe
	input  wire logic                             mcu_psen_n,       // fetch strobe
	input  wire logic                             mcu_ale,          // address latch strobe
	input  wire logic [ADDR_W-1:0]                mem_addr,         // memory address
	input  wire logic                             flash_sel,        // internal flash select
	input  wire logic                             sram_sel,         // internal sram select
	output logic                                  logic_bus_rd_n,   // gated read strobe
	output logic                                  logic_bus_wr_n,   // gated write strobe
	output logic                                  logic_bus_psen_n, // gated fetch strobe
	output logic                                  logic_bus_ale,    // gated latch strobe
	output logic                                  logic_bus_common_clock_in,  // gated clock-in
	output logic      [NUM_OMC-1:0]               omc_clock,        // macrocell common clock
	output logic                                  power_down_indicator, // module powered down
	output logic                                  addr_buf_on,      // address buffers on
	output logic                                  data_buf_on,      // data buffers on
	output logic                                  flash_wake,       // flash wake pulse
	output logic                                  sram_wake,        // sram wake pulse
	output logic                                  mem_standby,      // memories in standby
	output logic                                  logic_fast_mode,  // logic in fast mode
	output logic                                  logic_zero_power  // logic zero-power on
);
	import pmm_pkg::*;

	logic [2:0]       sync_q;
	logic             common_clock_in_s;
	logic             csi_s;
	logic             rstpin_s;

	pmm_sync #(
		.WIDTH(3)
	) u_sync (
		.sys_clk(sys_clk),
		.nrst   (nrst),
		.ce     (ce),
		.d_async({module_rst_n, aux_pin_in}),
		.q_sync (sync_q)
	);

	assign common_clock_in_s  = sync_q[0];
	assign csi_s    = sync_q[1];
	assign rstpin_s = sync_q[2];

	function automatic logic is_mode(input aux_mode_t m, input aux_mode_t want);
		is_mode = (m == want);
	endfunction

	// ---------------- control and power-down state
	logic [REG_W-1:0]     power_mode_control0;
	logic [REG_W-1:0]     next_ctrl;
	pd_state_t            state;
	pd_state_t            next_state;
	logic [APD_CNT_W-1:0] apd_count;
	logic [APD_CNT_W-1:0] next_count;
	logic                 common_clock_in_q;
	logic                 csi_q;
	logic                 rstpin_q;
	logic                 ale_q;
	logic                 next_pd;
	logic                 clk_rise;
	logic                 ale_change;
	logic                 csi_on;
	logic                 csi_fall;
	logic                 rst_rise;
	logic                 apd_en;

	assign apd_en     = power_mode_control0[APD_EN_BIT];
	// counter only sees clock-in when pin 0 is in its dedicated mode
	assign clk_rise   = common_clock_in_s && !common_clock_in_q && is_mode(aux_mode[0], AUX_DEDICATED); // R2
	assign ale_change = mcu_ale != ale_q;
	assign csi_on     = csi_s && is_mode(aux_mode[1], AUX_DEDICATED);
	assign csi_fall   = csi_q && !csi_on;
	assign rst_rise   = rstpin_s && !rstpin_q;

	always_comb begin
		next_ctrl  = power_mode_control0;
		next_state = state;
		next_count = apd_count;
		if (reg_wr) begin
			// unused bits are kept at zero whatever software writes
			next_ctrl = reg_wdata & PMC0_USED_MASK; // R16
		end
		if (!apd_en) begin
			next_state = PS_RUN; // R12
			next_count = '0;
		end else begin
			unique case (state)
				PS_RUN: begin
					next_state = PS_COUNT; // R12
					next_count = '0;
				end
				PS_COUNT: begin
					if (ale_change) begin
						next_count = '0; // R18
					end else if (clk_rise) begin
						next_count = apd_count + 4'h1; // R17
						if (apd_count == APD_MAX - 4'h1) begin
							next_state = PS_DOWN; // R17
						end
					end
				end
				PS_DOWN: begin
					if (ale_change || csi_fall || rst_rise) begin
						next_state = PS_COUNT; // R19
						next_count = '0;
					end
				end
				default: begin
					next_state = PS_RUN;
					next_count = '0;
				end
			endcase
		end
		if (!nrst) begin
			next_ctrl  = PMC0_RESET; // R20
			next_state = PS_RUN;
			next_count = '0;
		end
		next_pd = (next_state == PS_DOWN) || forced_power_down; // R21 R8
	end

	// module_rst_n is not a reset here: it only wakes the module, so the
	// control register survives it
	always_ff @(posedge sys_clk) begin
		if (ce || !nrst) begin
			power_mode_control0  <= next_ctrl; // R20
			state                <= next_state;
			apd_count            <= next_count;
			common_clock_in_q              <= nrst ? common_clock_in_s : 1'b0;
			csi_q                <= nrst ? csi_on : 1'b0;
			rstpin_q             <= nrst ? rstpin_s : 1'b0;
			ale_q                <= nrst ? mcu_ale : 1'b0;
			power_down_indicator <= nrst ? next_pd : 1'b0;
			addr_buf_on          <= nrst ? !next_pd : 1'b1; // R6
			data_buf_on          <= nrst ? !next_pd : 1'b1; // R6
			logic_fast_mode      <= !next_ctrl[FAST_OFF_BIT]; // R10 R13
			logic_zero_power     <= next_ctrl[FAST_OFF_BIT]; // R5
		end
	end

	assign reg_rdata = power_mode_control0;

	// ---------------- memory wake, strobes and pins
	logic [ADDR_W-1:0]  last_addr;
	logic [ADDR_W-1:0]  next_last_addr;
	logic               next_flash_wake;
	logic               next_sram_wake;
	logic               next_rd_n;
	logic               next_wr_n;
	logic               next_psen_n;
	logic               next_ale;
	logic               next_common_clock_in;
	logic [NUM_OMC-1:0] next_omc;
	logic [1:0]         next_pin_out;
	logic [1:0]         next_oe_n;
	logic [1:0]         next_logic_in;
	logic               addr_chg;

	// buffers off means the address seen by the memories stops moving
	assign addr_chg = (mem_addr != last_addr) && !power_down_indicator; // R6

	always_comb begin
		next_last_addr  = power_down_indicator ? last_addr : mem_addr; // R4
		// chip-select input overrides every internal select; buffers stay on
		next_flash_wake = addr_chg && flash_sel && !csi_on; // R3 R4 R9
		next_sram_wake  = addr_chg && sram_sel && !csi_on; // R3 R4 R9
		// strobes are gated only by blocking bits, never by power-down
		next_rd_n       = block_rd   ? 1'b1 : mcu_rd_n; // R11 R7
		next_wr_n       = block_wr   ? 1'b1 : mcu_wr_n; // R11 R7
		next_psen_n     = block_psen ? 1'b1 : mcu_psen_n; // R11 R7
		next_ale        = block_ale  ? 1'b0 : mcu_ale; // R11 R7
		next_common_clock_in      = is_mode(aux_mode[0], AUX_DEDICATED) && common_clock_in_s
			&& !power_mode_control0[BLOCK_COMMON_CLOCK_IN_BIT]; // R14
		next_omc        = {NUM_OMC{is_mode(aux_mode[0], AUX_DEDICATED) && common_clock_in_s
			&& !power_mode_control0[BLOCK_OMC_BIT]}}; // R2 R15
		for (int i = 0; i < NUM_AUX; i++) begin
			next_pin_out[i]  = 1'b0;
			next_oe_n[i]     = 1'b1;
			next_logic_in[i] = 1'b0;
			unique case (aux_mode[i])
				AUX_MCU_IO: begin
					next_pin_out[i] = mcu_pin_out[i]; // R1
					next_oe_n[i]    = !mcu_pin_dir[i];
				end
				AUX_CS_OUT: begin
					next_pin_out[i] = (i == 0) ? external_chip_select_1
						: external_chip_select_2; // R1
					next_oe_n[i]    = 1'b0;
				end
				AUX_LOGIC_IN: begin
					next_logic_in[i] = sync_q[i]; // R1
				end
				AUX_DEDICATED: begin
					next_oe_n[i] = 1'b1;
				end
			endcase
		end
		if (!nrst) begin
			next_last_addr  = '0;
			next_flash_wake = 1'b0;
			next_sram_wake  = 1'b0;
			next_rd_n       = 1'b1;
			next_wr_n       = 1'b1;
			next_psen_n     = 1'b1;
			next_ale        = 1'b0;
			next_common_clock_in      = 1'b0;
			next_omc        = '0;
			next_pin_out    = '0;
			next_oe_n       = '1;
			next_logic_in   = '0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (ce || !nrst) begin
			last_addr        <= next_last_addr;
			flash_wake       <= next_flash_wake;
			sram_wake        <= next_sram_wake;
			mem_standby      <= !(next_flash_wake || next_sram_wake); // R4
			logic_bus_rd_n   <= next_rd_n;
			logic_bus_wr_n   <= next_wr_n;
			logic_bus_psen_n <= next_psen_n;
			logic_bus_ale    <= next_ale;
			logic_bus_common_clock_in  <= next_common_clock_in;
			omc_clock        <= next_omc;
			aux_pin_out      <= next_pin_out;
			aux_pin_oe_n     <= next_oe_n;
			logic_in_aux     <= next_logic_in;
			mcu_pin_in       <= nrst ? sync_q[1:0] : 2'h0;
		end
	end

	// ---------------- checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);

	a_forced_pd_out: assert property (ce && forced_power_down |=> power_down_indicator) // R8
		else $error("forced power-down did not assert the indicator");
	a_pd_buffers_off: assert property (power_down_indicator |-> !addr_buf_on && !data_buf_on) // R6
		else $error("buffers on during power-down");
	a_pd_mem_quiet: assert property (ce && power_down_indicator |=> !flash_wake && !sram_wake) // R6
		else $error("memory woke during power-down");
	a_csi_standby: assert property (ce && csi_on |=> mem_standby && addr_buf_on == !power_down_indicator) // R3
		else $error("memory awake with chip-select input high");
	a_apd_timeout: assert property (ce && apd_en && state == PS_COUNT && apd_count == 4'hE // R17
		&& clk_rise && !ale_change |=> power_down_indicator && apd_count == 4'hF)
		else $error("counter did not time out at fifteen periods");
	a_ale_clears: assert property (ce && apd_en && state == PS_COUNT && ale_change // R18
		|=> apd_count == 4'h0 && state != PS_DOWN)
		else $error("latch strobe change did not clear the counter");
	a_apd_disabled: assert property (ce && !apd_en && !forced_power_down // R12
		|=> !power_down_indicator && apd_count == 4'h0)
		else $error("power-down while counter disabled");
	a_fast_mode_sel: assert property (ce && reg_wr |=> logic_fast_mode == !$past(reg_wdata[3])) // R13
		else $error("logic mode does not follow control write");
	a_strobe_block: assert property (ce |=> (!$past(block_ale) || !logic_bus_ale) // R11
		&& (!$past(block_rd) || logic_bus_rd_n) && (!$past(block_wr) || logic_bus_wr_n)
		&& (!$past(block_psen) || logic_bus_psen_n))
		else $error("blocked strobe reached the logic bus");
	a_common_clock_in_block: assert property (ce && power_mode_control0[BLOCK_COMMON_CLOCK_IN_BIT] |=> !logic_bus_common_clock_in) // R14
		else $error("clock-in reached logic bus while blocked");
	a_omc_block: assert property (ce && power_mode_control0[BLOCK_OMC_BIT] |=> omc_clock == '0) // R15
		else $error("clock-in reached macrocells while blocked");
	a_wake_exit: assert property (ce && state == PS_DOWN && apd_en && (csi_fall || rst_rise) // R19
		|=> state == PS_COUNT)
		else $error("wake event did not leave power-down");
endmodule

//--- test/slow_clock_model.sv
/*
 Behavioural model of the external slow clock feeding the common clock-in pin.
 Assumes the bench clock on sys_clk; the pin stands low while the clock is stopped.
*/
`timescale 1ns/1ns
module slow_clock_model (
	input  wire logic       sys_clk,     // bench clock
	input  wire logic       run,         // clock runs while high
	input  wire logic [7:0] half_cycles, // half period in sys_clk cycles
	output logic            clk_pin,     // clock-in pin level
	output logic [15:0]     rises        // rising edges produced so far
);
	logic [7:0] cnt;

	initial begin
		cnt = 8'h00;
		clk_pin = 1'h0;
		rises = 16'h0000;
	end

	// stops dead while run is low, so the power-down counter sees no clock-in periods
	always @(posedge sys_clk) begin
		if (!run) begin
			cnt <= 8'h00;
			clk_pin <= 1'h0;
		end else if (cnt == half_cycles - 8'h01) begin
			cnt <= 8'h00;
			clk_pin <= !clk_pin;
			rises <= rises + {15'h0000, !clk_pin};
		end else begin
			cnt <= cnt + 8'h01;
		end
	end
endmodule

//--- test/pld_memory_power_manager_bench.sv
/*
 Self-checking bench: register, strobe blocking, pin modes, memory wake,
 forced and automatic power-down. Assumes the slow clock model on pin 0.
*/
`timescale 1ns/1ns
module pld_memory_power_manager_bench;
	import pmm_pkg::*;
	logic            sys_clk, nrst, ce, reg_wr, forced_power_down, module_rst_n;
	logic            block_rd, block_wr, block_psen, block_ale, flash_sel, sram_sel;
	logic            external_chip_select_1, external_chip_select_2, clk_run, csi_lvl;
	logic            mcu_rd_n, mcu_wr_n, mcu_psen_n, mcu_ale, clk_pin, omc_ok;
	logic            logic_bus_rd_n, logic_bus_wr_n, logic_bus_psen_n, logic_bus_ale;
	logic            logic_bus_common_clock_in, power_down_indicator, addr_buf_on, data_buf_on;
	logic            flash_wake, sram_wake, mem_standby, logic_fast_mode, logic_zero_power;
	logic [7:0]      reg_wdata, reg_rdata;
	logic [1:0]      aux_pin_in, aux_pin_out, aux_pin_oe_n, mcu_pin_out, mcu_pin_dir;
	logic [1:0]      mcu_pin_in, logic_in_aux, seen;
	logic [3:0]      blk;
	logic [15:0]     mem_addr, omc_clock, rises;
	aux_mode_t [1:0] aux_mode;
	aux_mode_t       pin_modes [3] = '{AUX_MCU_IO, AUX_CS_OUT, AUX_LOGIC_IN};
	logic [7:0]      wr_tab [3] = '{8'h08, 8'h00, 8'hFF};
	logic [7:0]      rd_tab [3] = '{8'h08, 8'h00, 8'h3A};
	logic [1:0]      oe_tab [3] = '{2'h0, 2'h0, 2'h3};
	logic [1:0]      out_tab [3] = '{2'h2, 2'h1, 2'h2};
	logic [2:0]      wake_tab [3] = '{3'h4, 3'h2, 3'h1};
	int              num_errors = 0;
	int              checks_done = 0;

	pld_memory_power_manager dut (
		.sys_clk, .nrst, .ce, .reg_wr, .reg_wdata, .reg_rdata, .forced_power_down,
		.block_rd, .block_wr, .block_psen, .block_ale, .aux_mode, .aux_pin_in,
		.aux_pin_out, .aux_pin_oe_n, .mcu_pin_out, .mcu_pin_dir, .mcu_pin_in,
		.external_chip_select_1, .external_chip_select_2, .logic_in_aux, .module_rst_n,
		.mcu_rd_n, .mcu_wr_n, .mcu_psen_n, .mcu_ale, .mem_addr, .flash_sel, .sram_sel,
		.logic_bus_rd_n, .logic_bus_wr_n, .logic_bus_psen_n, .logic_bus_ale,
		.logic_bus_common_clock_in, .omc_clock, .power_down_indicator, .addr_buf_on, .data_buf_on,
		.flash_wake, .sram_wake, .mem_standby, .logic_fast_mode, .logic_zero_power
	);

	slow_clock_model partner (.sys_clk, .run(clk_run), .half_cycles(8'h08), .clk_pin, .rises);

	// a pin the design does not drive shows the far side's level
	assign aux_pin_in[0] = (aux_pin_oe_n[0] === 1'h0) ? aux_pin_out[0] : clk_pin;
	assign aux_pin_in[1] = (aux_pin_oe_n[1] === 1'h0) ? aux_pin_out[1] : csi_lvl;

	initial begin
		sys_clk = 1'h0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic end_test(input string name);
		$display("test %s done, %0d mismatches so far", name, num_errors);
	endtask

	task automatic wrap_up;
		$display("checks %0d, mismatches %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// one extra edge after the take; derived mode outputs load on the take edge itself
	task automatic write_reg(input logic [7:0] v);
		@(posedge sys_clk);
		reg_wr <= 1'h1;
		reg_wdata <= v;
		@(posedge sys_clk);
		reg_wr <= 1'h0;
		tick(1);
	endtask

	task automatic wait_ind(input logic v, input int lim);
		for (int n = 0; n < lim && power_down_indicator !== v; n++) tick(1);
	endtask

	// cut: toggle the latch strobe after 8 clock-in periods to restart the count
	task automatic run_to_down(input logic cut);
		logic [15:0] base;
		base = rises;
		@(posedge sys_clk);
		clk_run <= 1'h1;
		if (cut) begin
			for (int n = 0; n < 400 && rises != base + 16'h8; n++) @(posedge sys_clk);
			repeat (8) @(posedge sys_clk);
			mcu_ale <= ~mcu_ale;
			base = rises;
		end
		wait_ind(1'h1, 400);
		check_val(rises - base, 16'hF);
		check_val({addr_buf_on, data_buf_on}, 2'h0);
		@(posedge sys_clk);
		clk_run <= 1'h0;
	endtask

	initial begin
		{ce, nrst, reg_wr, reg_wdata, forced_power_down, module_rst_n} = 13'h1001;
		{block_rd, block_wr, block_psen, block_ale, flash_sel, sram_sel} = 6'h00;
		aux_mode[0] = AUX_MCU_IO;
		aux_mode[1] = AUX_MCU_IO;
		{mcu_pin_out, mcu_pin_dir, external_chip_select_1, external_chip_select_2} = 6'h00;
		{mcu_rd_n, mcu_wr_n, mcu_psen_n, mcu_ale, clk_run, csi_lvl} = 6'h38;
		mem_addr = 16'h0000;
		repeat (4) @(posedge sys_clk);
		nrst <= 1'h1;
		#1;
		check_val(reg_rdata, 8'h00);
		check_val({logic_fast_mode, logic_zero_power}, 2'h2);
		check_val({power_down_indicator, addr_buf_on, mem_standby}, 3'h3);
		end_test("reset");
		for (int i = 0; i < 3; i++) begin
			write_reg(wr_tab[i]);
			check_val(reg_rdata, rd_tab[i]);
			check_val({logic_fast_mode, logic_zero_power}, {!rd_tab[i][3], rd_tab[i][3]});
		end
		// a write while the clock enable is low must leave every flop alone
		@(posedge sys_clk);
		ce <= 1'h0;
		write_reg(8'h08);
		check_val({reg_rdata, logic_fast_mode, logic_zero_power}, {8'h3A, 2'h1});
		@(posedge sys_clk);
		ce <= 1'h1;
		write_reg(8'h00);
		end_test("register");
		@(posedge sys_clk);
		{mcu_rd_n, mcu_wr_n, mcu_psen_n, mcu_ale} <= 4'h1;
		for (int i = 0; i < 5; i++) begin
			blk = 4'(1 << i);
			@(posedge sys_clk);
			{block_rd, block_wr, block_psen, block_ale} <= blk;
			tick(2);
			check_val({logic_bus_rd_n, logic_bus_wr_n, logic_bus_psen_n, logic_bus_ale},
				4'h1 ^ blk);
		end
		@(posedge sys_clk);
		{mcu_rd_n, mcu_wr_n, mcu_psen_n, mcu_ale, block_rd, block_wr, block_psen,
			block_ale} <= 8'hE0;
		end_test("strobes");
		@(posedge sys_clk);
		{external_chip_select_2, external_chip_select_1, mcu_pin_out, mcu_pin_dir} <= 6'h1B;
		csi_lvl <= 1'h1;
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk);
			aux_mode[0] <= pin_modes[i];
			aux_mode[1] <= pin_modes[i];
			tick(4);
			check_val(aux_pin_oe_n, oe_tab[i]);
			check_val((i == 2) ? logic_in_aux : aux_pin_out, out_tab[i]);
			check_val({mcu_pin_in, logic_in_aux}, {out_tab[i], (i == 2) ? out_tab[i] : 2'h0});
		end
		end_test("pin modes");
		@(posedge sys_clk);
		aux_mode[0] <= AUX_DEDICATED;
		aux_mode[1] <= AUX_DEDICATED;
		for (int i = 0; i < 3; i++) begin
			@(posedge sys_clk);
			{csi_lvl, flash_sel, sram_sel} <= {i == 2, i != 1, i != 0};
			tick(4);
			@(posedge sys_clk);
			mem_addr <= mem_addr + 16'h0101;
			tick(1);
			check_val({flash_wake, sram_wake, mem_standby}, wake_tab[i]);
			check_val({addr_buf_on, logic_fast_mode}, 2'h3);
			tick(1);
			check_val({flash_wake, sram_wake, mem_standby}, 3'h1);
		end
		end_test("memory wake");
		@(posedge sys_clk);
		{csi_lvl, forced_power_down} <= 2'h1;
		tick(1);
		check_val({power_down_indicator, addr_buf_on, data_buf_on}, 3'h4);
		@(posedge sys_clk);
		mem_addr <= mem_addr + 16'h0001;
		mcu_rd_n <= 1'h0;
		tick(1);
		check_val({flash_wake, sram_wake, mem_standby, logic_bus_rd_n}, 4'h2);
		@(posedge sys_clk);
		{forced_power_down, mcu_rd_n} <= 2'h1;
		tick(1);
		check_val(power_down_indicator, 1'h0);
		end_test("forced power-down");
		@(posedge sys_clk);
		clk_run <= 1'h1;
		for (int i = 0; i < 4; i++) begin
			write_reg({2'h0, 2'(i), 4'h0});
			{seen, omc_ok} = 3'h1;
			for (int k = 0; k < 40; k++) begin
				tick(1);
				seen |= {logic_bus_common_clock_in, |omc_clock};
				if (omc_clock !== {16{omc_clock[0]}}) omc_ok = 1'h0;
			end
			check_val(seen, {!i[0], !i[1]});
			check_val(omc_ok, 1'h1);
		end
		tick(256);
		check_val(power_down_indicator, 1'h0);
		end_test("clock-in gating");
		@(posedge sys_clk);
		clk_run <= 1'h0;
		write_reg(8'h02);
		for (int k = 0; k < 3; k++) begin
			@(posedge sys_clk);
			{csi_lvl, module_rst_n} <= {k == 1, k != 2};
			tick(4);
			run_to_down(k == 0);
			@(posedge sys_clk);
			case (k)
				0: mcu_ale <= ~mcu_ale;
				1: csi_lvl <= 1'h0;
				default: module_rst_n <= 1'h1;
			endcase
			wait_ind(1'h0, 8);
			check_val({power_down_indicator, addr_buf_on}, 2'h1);
		end
		check_val(reg_rdata, 8'h02);
		end_test("automatic power-down");
		wrap_up;
	end

	initial begin
		repeat (20000) @(posedge sys_clk);
		num_errors++;
		$display("mismatch at %0t ns: run overdue, got %h expected %h", $time, 1'h0, 1'h1);
		wrap_up;
	end
endmodule
